// ==== shared/cacco_pkg.sv ====
// constants for the counter array channel compare and output block
// assumes an 8-bit special-function register bus with byte addresses
package cacco_pkg;

    // register addresses on the special-function register bus
    localparam logic [7:0] CHANNEL_OUTPUT_POLARITY_ADDR  = 8'h96;
    localparam logic [7:0] CHANNEL_CENTER_ALIGNMENT_ADDR = 8'h9E;
    localparam logic [7:0] CHANNEL0_COMPARE_LOW_ADDR     = 8'hFB;
    localparam logic [7:0] CHANNEL0_COMPARE_HIGH_ADDR    = 8'hFC;

    // widths and reset values
    localparam int         NUM_CHANNELS      = 3;
    localparam logic [7:0] BYTE_RESET        = 8'h00;
    localparam logic [2:0] CHAN_BITS_RESET   = 3'h0;
    localparam logic [7:0] READ_IDLE         = 8'h00;
    // writable field of polarity and alignment registers is bits 2:0
    localparam int         CHAN_FIELD_MSB    = 2;
    localparam int         RESERVED_LSB      = 3;
    localparam int         RESERVED_MSB      = 7;
    localparam logic [4:0] RESERVED_VALUE    = 5'h00;
    // comparator enable after reset, and forced values on byte writes
    localparam logic       CMP_EN_RESET      = 1'b0;
    localparam logic       CMP_EN_ON_LOW_WR  = 1'b0;
    localparam logic       CMP_EN_ON_HIGH_WR = 1'b1;
    // read data is registered: answer one cycle after the read strobe
    localparam int         READ_LATENCY      = 1;

    // what a bus address selects, after the reload-select steering
    typedef enum logic [2:0] {
        TGT_NONE,
        TGT_POLARITY,
        TGT_ALIGNMENT,
        TGT_COMPARE_LOW,
        TGT_COMPARE_HIGH,
        TGT_RELOAD_LOW,
        TGT_RELOAD_HIGH
    } cacco_target_type;

endpackage

// ==== rtl/cacco_output_stage.sv ====
// one channel's pin stage: polarity inversion and alignment gating
// assumes the raw waveform comes from the channel's mode logic on clk
`timescale 1ns/1ps
module cacco_output_stage (
    input  wire logic pwm_mode,
    input  wire logic raw_level,
    input  wire logic invert,
    input  wire logic center_bit,
    output logic      pin_level,
    output logic      center_active
);
    import cacco_pkg::*;

    // combinational so a polarity change reaches the pin at once
    assign pin_level     = raw_level ^ invert;
    // alignment only means something while the channel runs pwm
    assign center_active = center_bit & pwm_mode;

endmodule // cacco_output_stage

// ==== rtl/cacco_top.sv ====
// Function
// - low byte of channel 0 compare, reset zero
// - reload select steers low address to reload
// - low byte write clears comparator enable
// - high byte of channel 0 compare, reset zero
// - reload select steers high address to reload
// - high byte write sets comparator enable
// - polarity bit per channel inverts its output
// - polarity change reaches pin immediately
// - alignment bit per channel: edge or center
// - alignment applies only in pwm modes
// - comparator enable turns compare function on
// - width bit picks 8-11 or 16-bit pwm
//
// top of the channel compare registers and pin output stages
// assumes a byte-wide register bus with single-cycle write strobes
`timescale 1ns/1ps
module cacco_top (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic [7:0]  sfr_wdata,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    output logic      [7:0]  sfr_rdata,
    input  wire logic        reload_select,
    input  wire logic [15:0] counter_value,
    input  wire logic        mode0_wr,
    input  wire logic        mode0_cmp_en_wdata,
    input  wire logic [2:0]  channel_pwm_mode,
    input  wire logic [2:0]  pwm_width_select,
    input  wire logic [2:0]  channel_raw,
    output logic      [2:0]  channel_output,
    output logic      [2:0]  channel_center_active,
    output logic             comparator_function_enable,
    output logic      [15:0] channel0_compare_value,
    output logic      [15:0] channel0_reload_value,
    output logic             channel0_reload_active,
    output logic             channel0_match
);
    import cacco_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // decode

    // one place for the address map so reads and writes agree
    function automatic cacco_target_type decode_target(
        input logic [7:0] addr,
        input logic       steer
    );
        cacco_target_type t;
        t = TGT_NONE;
        case (addr)
            CHANNEL_OUTPUT_POLARITY_ADDR:  t = TGT_POLARITY;
            CHANNEL_CENTER_ALIGNMENT_ADDR: t = TGT_ALIGNMENT;
            CHANNEL0_COMPARE_LOW_ADDR:     t = steer ? TGT_RELOAD_LOW : TGT_COMPARE_LOW;
            CHANNEL0_COMPARE_HIGH_ADDR:    t = steer ? TGT_RELOAD_HIGH : TGT_COMPARE_HIGH;
            default:                       t = TGT_NONE;
        endcase
        return t;
    endfunction

    cacco_target_type target;
    logic             wr_low_addr;
    logic             wr_high_addr;
    logic [7:0]       compare_low_reg;
    logic [7:0]       compare_high_reg;
    logic [7:0]       reload_low_reg;
    logic [7:0]       reload_high_reg;
    logic [2:0]       polarity_reg;
    logic [2:0]       alignment_reg;
    logic             cmp_en_reg;
    logic             match_reg;
    logic [7:0]       rdata_reg;

    assign target       = decode_target(sfr_addr, reload_select);
    // the enable side effect follows the address, whichever byte is hit
    assign wr_low_addr  = sfr_wr && (sfr_addr == CHANNEL0_COMPARE_LOW_ADDR);
    assign wr_high_addr = sfr_wr && (sfr_addr == CHANNEL0_COMPARE_HIGH_ADDR);

    ////////////////////////////////////////////////////////////////////
    // storage

    // compare bytes
    always_ff @(posedge clk) begin
        if (srst) begin
            compare_low_reg  <= BYTE_RESET;
            compare_high_reg <= BYTE_RESET;
        end else if (sfr_wr) begin
            if (target == TGT_COMPARE_LOW) begin
                compare_low_reg <= sfr_wdata;
            end
            if (target == TGT_COMPARE_HIGH) begin
                compare_high_reg <= sfr_wdata;
            end
        end
    end

    // auto-reload bytes for the 9 to 11-bit pwm modes
    always_ff @(posedge clk) begin
        if (srst) begin
            reload_low_reg  <= BYTE_RESET;
            reload_high_reg <= BYTE_RESET;
        end else if (sfr_wr) begin
            if (target == TGT_RELOAD_LOW) begin
                reload_low_reg <= sfr_wdata;
            end
            if (target == TGT_RELOAD_HIGH) begin
                reload_high_reg <= sfr_wdata;
            end
        end
    end

    // polarity and alignment; reserved bits are simply not stored
    always_ff @(posedge clk) begin
        if (srst) begin
            polarity_reg  <= CHAN_BITS_RESET;
            alignment_reg <= CHAN_BITS_RESET;
        end else if (sfr_wr) begin
            if (target == TGT_POLARITY) begin
                polarity_reg <= sfr_wdata[CHAN_FIELD_MSB:0];
            end
            if (target == TGT_ALIGNMENT) begin
                alignment_reg <= sfr_wdata[CHAN_FIELD_MSB:0];
            end
        end
    end

    // comparator enable: byte writes win over a mode register write,
    // so a low-then-high update always ends with the compare running
    always_ff @(posedge clk) begin
        if (srst) begin
            cmp_en_reg <= CMP_EN_RESET;
        end else if (wr_low_addr) begin
            cmp_en_reg <= CMP_EN_ON_LOW_WR;
        end else if (wr_high_addr) begin
            cmp_en_reg <= CMP_EN_ON_HIGH_WR;
        end else if (mode0_wr) begin
            cmp_en_reg <= mode0_cmp_en_wdata;
        end
    end

    // match only while the comparator is on
    always_ff @(posedge clk) begin
        if (srst) begin
            match_reg <= 1'b0;
        end else begin
            match_reg <= cmp_en_reg &&
                         (counter_value == {compare_high_reg, compare_low_reg});
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read path

    // registered read: one cycle latency, unmapped reads return zero
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_reg <= READ_IDLE;
        end else if (sfr_rd) begin
            case (target)
                TGT_POLARITY:     rdata_reg <= {RESERVED_VALUE, polarity_reg};
                TGT_ALIGNMENT:    rdata_reg <= {RESERVED_VALUE, alignment_reg};
                TGT_COMPARE_LOW:  rdata_reg <= compare_low_reg;
                TGT_COMPARE_HIGH: rdata_reg <= compare_high_reg;
                TGT_RELOAD_LOW:   rdata_reg <= reload_low_reg;
                TGT_RELOAD_HIGH:  rdata_reg <= reload_high_reg;
                default:          rdata_reg <= READ_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs

    assign sfr_rdata                  = rdata_reg;
    assign comparator_function_enable = cmp_en_reg;
    assign channel0_compare_value     = {compare_high_reg, compare_low_reg};
    assign channel0_reload_value      = {reload_high_reg, reload_low_reg};
    assign channel0_match             = match_reg;
    // reload value only feeds the narrow pwm modes, not 16-bit
    assign channel0_reload_active     = channel_pwm_mode[0] & ~pwm_width_select[0];

    // pin stages, one per channel
    for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : g_stage
        cacco_output_stage u_stage (
            .pwm_mode      (channel_pwm_mode[ch]),
            .raw_level     (channel_raw[ch]),
            .invert        (polarity_reg[ch]),
            .center_bit    (alignment_reg[ch]),
            .pin_level     (channel_output[ch]),
            .center_active (channel_center_active[ch])
        );
    end

    ////////////////////////////////////////////////////////////////////
    // assertions

    sequence s_low_write(logic [7:0] d);
        sfr_wr && sfr_addr == CHANNEL0_COMPARE_LOW_ADDR && !reload_select && sfr_wdata == d;
    endsequence

    sequence s_high_write(logic [7:0] d);
        sfr_wr && sfr_addr == CHANNEL0_COMPARE_HIGH_ADDR && !reload_select
            && sfr_wdata == d;
    endsequence

    AST_LOW_WRITE_CLEARS_EN: assert property (@(posedge clk) disable iff (srst)
        wr_low_addr |=> !comparator_function_enable)
        else $error("low byte write did not clear comparator enable");

    AST_HIGH_WRITE_SETS_EN: assert property (@(posedge clk) disable iff (srst)
        wr_high_addr |=> comparator_function_enable)
        else $error("high byte write did not set comparator enable");

    AST_LOW_STORE: assert property (@(posedge clk) disable iff (srst)
        (wr_low_addr && !reload_select)
            |=> channel0_compare_value[7:0] == $past(sfr_wdata)
                && $stable(channel0_reload_value))
        else $error("compare low byte not stored");

    AST_RELOAD_LOW: assert property (@(posedge clk) disable iff (srst)
        (wr_low_addr && reload_select)
            |=> channel0_reload_value[7:0] == $past(sfr_wdata)
                && $stable(channel0_compare_value))
        else $error("reload low byte not steered");

    AST_HIGH_STORE: assert property (@(posedge clk) disable iff (srst)
        (wr_high_addr && !reload_select)
            |=> channel0_compare_value[15:8] == $past(sfr_wdata))
        else $error("compare high byte not stored");

    AST_RELOAD_HIGH: assert property (@(posedge clk) disable iff (srst)
        (wr_high_addr && reload_select)
            |=> channel0_reload_value[15:8] == $past(sfr_wdata)
                && $stable(channel0_compare_value))
        else $error("reload high byte not steered");

    AST_POLARITY_PIN: assert property (@(posedge clk) disable iff (srst)
        (sfr_wr && sfr_addr == CHANNEL_OUTPUT_POLARITY_ADDR)
            |=> channel_output == (channel_raw ^ $past(sfr_wdata[2:0])))
        else $error("polarity not applied at the pin on the next cycle");

    AST_ALIGN_GATED: assert property (@(posedge clk) disable iff (srst)
        (channel_center_active & ~channel_pwm_mode) == 3'h0)
        else $error("center alignment active outside pwm mode");

    AST_MATCH_NEEDS_EN: assert property (@(posedge clk) disable iff (srst)
        channel0_match |-> $past(comparator_function_enable))
        else $error("match raised with comparator disabled");

    AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (srst)
        (sfr_rd && (sfr_addr == CHANNEL_OUTPUT_POLARITY_ADDR
                    || sfr_addr == CHANNEL_CENTER_ALIGNMENT_ADDR))
            |=> sfr_rdata[7:3] == 5'h00)
        else $error("reserved bits read non-zero");

    AST_TWO_BYTE_UPDATE: assert property (@(posedge clk) disable iff (srst)
        (s_low_write(8'h5A) ##1 s_high_write(8'hA5))
            |=> comparator_function_enable && channel0_compare_value == 16'hA55A)
        else $error("low then high update did not re-enable with new value");

endmodule // cacco_top

// ==== test/cacco_load_model.sv ====
// external load on the three channel pins: a plain sampling receiver
// assumes pins are driven from the block on clk, reset is srst active high
`timescale 1ns/1ps
module cacco_load_model (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic [2:0] pin_level,
    output logic      [2:0] load_level
);
    // the load only registers what it sees, so it never feeds back
    always_ff @(posedge clk) begin
        if (srst) begin
            load_level <= 3'h0;
        end else begin
            load_level <= pin_level;
        end
    end
endmodule // cacco_load_model

// ==== test/testbench.sv ====
// self-checking bench for the channel compare registers and pin stages
// assumes cacco_top with registered read data, one cycle after the strobe
`timescale 1ns/1ps
module testbench;
    import cacco_pkg::*;
    `define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
        $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
    ////////////////////////////////////////////////////////////////////////////
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [7:0]  sfr_addr = 8'h00;
    logic [7:0]  sfr_wdata = 8'h00;
    logic        sfr_wr = 1'b0;
    logic        sfr_rd = 1'b0;
    logic [7:0]  sfr_rdata;
    logic        reload_select = 1'b0;
    logic [15:0] counter_value = 16'h0000;
    logic        mode0_wr = 1'b0;
    logic        mode0_cmp_en_wdata = 1'b0;
    logic [2:0]  channel_pwm_mode = 3'h0;
    logic [2:0]  pwm_width_select = 3'h0;
    logic [2:0]  channel_raw = 3'h0;
    logic [2:0]  channel_output;
    logic [2:0]  channel_center_active;
    logic        comparator_function_enable;
    logic [15:0] channel0_compare_value;
    logic [15:0] channel0_reload_value;
    logic        channel0_reload_active;
    logic        channel0_match;
    logic [2:0]  load_level;
    logic [7:0]  exp_q[$];
    logic [7:0]  exp_byte;
    logic        rd_seen = 1'b0;
    int          n_mismatch = 0;
    int          comparisons = 0;
    int          seed = 26982;
    ////////////////////////////////////////////////////////////////////////////
    cacco_top i_dut (.clk(clk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
        .reload_select(reload_select), .counter_value(counter_value),
        .mode0_wr(mode0_wr), .mode0_cmp_en_wdata(mode0_cmp_en_wdata),
        .channel_pwm_mode(channel_pwm_mode), .pwm_width_select(pwm_width_select),
        .channel_raw(channel_raw), .channel_output(channel_output),
        .channel_center_active(channel_center_active),
        .comparator_function_enable(comparator_function_enable),
        .channel0_compare_value(channel0_compare_value),
        .channel0_reload_value(channel0_reload_value),
        .channel0_reload_active(channel0_reload_active), .channel0_match(channel0_match));
    cacco_load_model i_load (.clk(clk), .srst(srst), .pin_level(channel_output),
        .load_level(load_level));
    // 200 MHz clock
    initial begin
        forever #2.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    // one write strobe; returns just after the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
        #1;
    endtask
    // one read strobe; the expectation goes on the queue
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        sfr_rd <= 1'b0;
    endtask
    task automatic tally_and_finish;
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // read data stands from the edge after the strobe; look mid-cycle
    always @(posedge clk) begin
        rd_seen <= sfr_rd;
    end
    always @(negedge clk) begin
        if (rd_seen && exp_q.size() > 0) begin
            // pop once: the macro evaluates its expected argument twice
            exp_byte = exp_q.pop_front();
            `CHK(sfr_rdata, exp_byte)
        end
    end
    // cut a hang short well past the expected run of under two hundred cycles
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        tally_and_finish();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [2:0] m;
        logic [2:0] w;
        logic [2:0] r;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        // reset values, then an unmapped address
        rd(CHANNEL0_COMPARE_LOW_ADDR, 8'h00);
        rd(CHANNEL0_COMPARE_HIGH_ADDR, 8'h00);
        rd(CHANNEL_OUTPUT_POLARITY_ADDR, 8'h00);
        rd(CHANNEL_CENTER_ALIGNMENT_ADDR, 8'h00);
        rd(8'h55, READ_IDLE);
        // mode write sets the enable, a low byte write clears it
        @(posedge clk);
        mode0_wr <= 1'b1;
        mode0_cmp_en_wdata <= 1'b1;
        @(posedge clk);
        mode0_wr <= 1'b0;
        #1 `CHK(comparator_function_enable, 1'b1)
        wr(CHANNEL0_COMPARE_LOW_ADDR, 8'h5A);
        `CHK(comparator_function_enable, 1'b0)
        wr(CHANNEL0_COMPARE_HIGH_ADDR, 8'hA5);
        `CHK(comparator_function_enable, 1'b1)
        `CHK(channel0_compare_value, 16'hA55A)
        // match one cycle after the count equals the compare value
        @(posedge clk);
        counter_value <= 16'hA55A;
        @(posedge clk);
        counter_value <= 16'h0001;
        #1 `CHK(channel0_match, 1'b1)
        @(posedge clk);
        #1 `CHK(channel0_match, 1'b0)
        // steering to the reload bytes leaves the compare bytes alone
        @(posedge clk);
        reload_select <= 1'b1;
        wr(CHANNEL0_COMPARE_LOW_ADDR, 8'h3C);
        `CHK(comparator_function_enable, 1'b0)
        wr(CHANNEL0_COMPARE_HIGH_ADDR, 8'h07);
        `CHK(channel0_reload_value, 16'h073C)
        `CHK(channel0_compare_value, 16'hA55A)
        rd(CHANNEL0_COMPARE_LOW_ADDR, 8'h3C);
        rd(CHANNEL0_COMPARE_HIGH_ADDR, 8'h07);
        @(posedge clk);
        reload_select <= 1'b0;
        rd(CHANNEL0_COMPARE_HIGH_ADDR, 8'hA5);
        // every polarity pattern, reserved bits kept zero
        for (int i = 0; i < 8; i++) begin
            wr(CHANNEL_OUTPUT_POLARITY_ADDR, {RESERVED_VALUE, 3'(i)});
            `CHK(channel_output, channel_raw ^ 3'(i))
            r = 3'($random(seed));
            @(posedge clk);
            channel_raw <= r;
            #1 `CHK(channel_output, r ^ 3'(i))
            @(posedge clk);
            #1 `CHK(load_level, r ^ 3'(i))
            rd(CHANNEL_OUTPUT_POLARITY_ADDR, {5'h00, 3'(i)});
        end
        // alignment only counts where the channel is in pwm mode
        for (int i = 0; i < 8; i++) begin
            wr(CHANNEL_CENTER_ALIGNMENT_ADDR, {RESERVED_VALUE, 3'(i)});
            rd(CHANNEL_CENTER_ALIGNMENT_ADDR, {5'h00, 3'(i)});
            for (int j = 0; j < 4; j++) begin
                m = 3'($random(seed));
                w = 3'($random(seed));
                @(posedge clk);
                channel_pwm_mode <= m;
                pwm_width_select <= w;
                #1 `CHK(channel_center_active, 3'(i) & m)
                `CHK(channel0_reload_active, m[0] & ~w[0])
            end
        end
        // mode write of zero: no match although the count equals compare
        @(posedge clk);
        mode0_wr <= 1'b1;
        mode0_cmp_en_wdata <= 1'b0;
        @(posedge clk);
        mode0_wr <= 1'b0;
        counter_value <= 16'hA55A;
        #1 `CHK(comparator_function_enable, 1'b0)
        @(posedge clk);
        #1 `CHK(channel0_match, 1'b0)
        wr(CHANNEL0_COMPARE_HIGH_ADDR, 8'h11);
        // back-to-back low/high update; a colliding mode write loses
        @(posedge clk);
        sfr_addr <= CHANNEL0_COMPARE_LOW_ADDR;
        sfr_wdata <= 8'h5A;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_addr <= CHANNEL0_COMPARE_HIGH_ADDR;
        sfr_wdata <= 8'hA5;
        mode0_wr <= 1'b1;
        #1 `CHK(comparator_function_enable, 1'b0)
        @(posedge clk);
        sfr_wr <= 1'b0;
        mode0_wr <= 1'b0;
        #1 `CHK(comparator_function_enable, 1'b1)
        `CHK(channel0_compare_value, 16'hA55A)
        @(posedge clk);
        #1 `CHK(channel0_match, 1'b1)
        repeat (3) @(posedge clk);
        tally_and_finish();
    end
endmodule // testbench
